/* File: hw/ipb_pkg.sv */
// Package with register map, field layout and types of the priority, break and sense block.
package ipb_pkg;
  localparam logic [11:0] OFF_PRIO_A = 12'h000;
  localparam logic [11:0] OFF_PRIO_B = 12'h004;
  localparam logic [11:0] OFF_PRIO_C = 12'h008;
  localparam logic [11:0] OFF_PRIO_D = 12'h00c;
  localparam logic [11:0] OFF_BRK_CTRL = 12'h010;
  localparam logic [11:0] OFF_BRK_HIGH = 12'h014;
  localparam logic [11:0] OFF_BRK_MID = 12'h018;
  localparam logic [11:0] OFF_BRK_LOW = 12'h01c;
  localparam logic [11:0] OFF_SENSE_UH = 12'h020;
  localparam logic [11:0] OFF_SENSE_UL = 12'h024;
  localparam logic [11:0] OFF_SENSE_LH = 12'h028;
  localparam logic [11:0] OFF_SENSE_LL = 12'h02c;
  localparam logic [11:0] OFF_PIN_SEL = 12'h030;
  localparam logic [11:0] OFF_REQ_EN = 12'h034;
  localparam logic [11:0] OFF_REQ_PEND = 12'h038;
  localparam int BRK_FLAG_BIT = 7;
  localparam int BRK_EN_BIT = 0;
  localparam logic [7:0] BRK_LOW_MASK = 8'hfe;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam int NUM_REQ = 16;

  typedef enum logic [1:0] {
    SENSE_LOW,
    SENSE_FALL,
    SENSE_RISE,
    SENSE_BOTH
  } ipb_sense_t;

  typedef struct packed {
    logic [23:0] addr;
    logic valid;
    logic prefetch;
  } ipb_fetch_t;
endpackage : ipb_pkg

/* File: hw/ipb_top.sv */
// Priority bits, address break unit and external request sense logic with APB registers.
//
// Operation
// - Set bit gives source level one
// - Nonmaskable interrupt ignores all priority bits
// - Fixed bit to source mapping per register
// - Break request when flag and enable set
// - Flag sets on enabled prefetch address match
// - Flag clears on break exception handling
// - Control bits six to one read zero
// - Control bit zero enables breaks
// - Normal mode skips upper address byte
// - High register compares address bits 23-16
// - Mid register compares address bits 15-8
// - Low register compares bits 7-1 only
// - Low register bit zero reads zero
// - Two-bit field selects level or edges
// - Upper sense registers hold requests 15-8
// - Sense uses primary or alternate pin
// - Requests 7-0 use lower sense registers
// - Detected request forwarded only when enabled
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module ipb_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire ipb_pkg::ipb_fetch_t i_fetch,
  input wire logic i_normal_mode,
  input wire logic i_break_ack,
  input wire logic [15:0] i_req_pin_n,
  input wire logic [15:0] i_alt_req_pin_n,
  input wire logic [15:0] i_req_ack,
  output logic o_break_req,
  output logic [15:0] o_ext_req,
  output logic [31:0] o_priority_level
);
  logic [7:0] prio_a_r;
  logic [7:0] prio_b_r;
  logic [7:0] prio_c_r;
  logic [7:0] prio_d_r;
  logic match_flag_r;
  logic brk_en_r;
  logic [7:0] brk_high_r;
  logic [7:0] brk_mid_r;
  logic [7:0] brk_low_r;
  logic [15:0] sense_upper_r;
  logic [15:0] sense_lower_r;
  logic [15:0] pin_sel_r;
  logic [15:0] req_en_r;
  logic [15:0] pend_r;
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  logic [15:0] prev_r;
  logic [15:0] pin_sel_eff;
  logic [15:0] raw_in;
  logic [15:0] detect;
  logic [31:0] rdata_nxt;
  logic setup;
  logic wr;
  logic rd;
  logic addr_hit;
  logic hit;
  // One write strobe per register except the pending register, each high for the setup cycle of a write to it.
  logic wr_prio_a;
  logic wr_prio_b;
  logic wr_prio_c;
  logic wr_prio_d;
  logic wr_brk_ctrl;
  logic wr_brk_high;
  logic wr_brk_mid;
  logic wr_brk_low;
  logic wr_sense_uh;
  logic wr_sense_ul;
  logic wr_sense_lh;
  logic wr_sense_ll;
  logic wr_pin_sel;
  logic wr_req_en;

  assign setup = i_psel && !i_penable;
  assign wr = setup && i_pwrite;
  assign rd = setup && !i_pwrite;

  // Writes take effect at the setup edge, so the answer never waits on storage.
  assign wr_prio_a = wr && i_paddr == ipb_pkg::OFF_PRIO_A;
  assign wr_prio_b = wr && i_paddr == ipb_pkg::OFF_PRIO_B;
  assign wr_prio_c = wr && i_paddr == ipb_pkg::OFF_PRIO_C;
  assign wr_prio_d = wr && i_paddr == ipb_pkg::OFF_PRIO_D;
  assign wr_brk_ctrl = wr && i_paddr == ipb_pkg::OFF_BRK_CTRL;
  assign wr_brk_high = wr && i_paddr == ipb_pkg::OFF_BRK_HIGH;
  assign wr_brk_mid = wr && i_paddr == ipb_pkg::OFF_BRK_MID;
  assign wr_brk_low = wr && i_paddr == ipb_pkg::OFF_BRK_LOW;
  assign wr_sense_uh = wr && i_paddr == ipb_pkg::OFF_SENSE_UH;
  assign wr_sense_ul = wr && i_paddr == ipb_pkg::OFF_SENSE_UL;
  assign wr_sense_lh = wr && i_paddr == ipb_pkg::OFF_SENSE_LH;
  assign wr_sense_ll = wr && i_paddr == ipb_pkg::OFF_SENSE_LL;
  assign wr_pin_sel = wr && i_paddr == ipb_pkg::OFF_PIN_SEL;
  assign wr_req_en = wr && i_paddr == ipb_pkg::OFF_REQ_EN;

  // Registers answer in the access cycle right after setup; no wait states.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= setup;
    end
  end

  // An address outside the map is refused in the same answer.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= setup && !addr_hit;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    addr_hit = 1'b1;
    if (i_paddr == ipb_pkg::OFF_PRIO_A) begin
      rdata_nxt[7:0] = prio_a_r;
    end else if (i_paddr == ipb_pkg::OFF_PRIO_B) begin
      rdata_nxt[7:0] = prio_b_r;
    end else if (i_paddr == ipb_pkg::OFF_PRIO_C) begin
      rdata_nxt[7:0] = prio_c_r;
    end else if (i_paddr == ipb_pkg::OFF_PRIO_D) begin
      rdata_nxt[7:0] = prio_d_r;
    end else if (i_paddr == ipb_pkg::OFF_BRK_CTRL) begin
      rdata_nxt[ipb_pkg::BRK_FLAG_BIT] = match_flag_r;
      rdata_nxt[ipb_pkg::BRK_EN_BIT] = brk_en_r;
    end else if (i_paddr == ipb_pkg::OFF_BRK_HIGH) begin
      rdata_nxt[7:0] = brk_high_r;
    end else if (i_paddr == ipb_pkg::OFF_BRK_MID) begin
      rdata_nxt[7:0] = brk_mid_r;
    end else if (i_paddr == ipb_pkg::OFF_BRK_LOW) begin
      rdata_nxt[7:0] = brk_low_r;
    end else if (i_paddr == ipb_pkg::OFF_SENSE_UH) begin
      rdata_nxt[7:0] = sense_upper_r[15:8];
    end else if (i_paddr == ipb_pkg::OFF_SENSE_UL) begin
      rdata_nxt[7:0] = sense_upper_r[7:0];
    end else if (i_paddr == ipb_pkg::OFF_SENSE_LH) begin
      rdata_nxt[7:0] = sense_lower_r[15:8];
    end else if (i_paddr == ipb_pkg::OFF_SENSE_LL) begin
      rdata_nxt[7:0] = sense_lower_r[7:0];
    end else if (i_paddr == ipb_pkg::OFF_PIN_SEL) begin
      rdata_nxt[15:0] = pin_sel_r;
    end else if (i_paddr == ipb_pkg::OFF_REQ_EN) begin
      rdata_nxt[15:0] = req_en_r;
    end else if (i_paddr == ipb_pkg::OFF_REQ_PEND) begin
      rdata_nxt[15:0] = pend_r;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Read data is captured at setup and held until the next read.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd) begin
      o_prdata <= rdata_nxt;
    end
  end

  // Priority bits; unassigned positions are stored as written by software.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prio_a_r <= ipb_pkg::RST_BYTE;
    end else if (wr_prio_a) begin
      prio_a_r <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prio_b_r <= ipb_pkg::RST_BYTE;
    end else if (wr_prio_b) begin
      prio_b_r <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prio_c_r <= ipb_pkg::RST_BYTE;
    end else if (wr_prio_c) begin
      prio_c_r <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prio_d_r <= ipb_pkg::RST_BYTE;
    end else if (wr_prio_d) begin
      prio_d_r <= i_pwdata[7:0];
    end
  end

  // Bit n gives level 1 to its source; the nonmaskable input is not among them.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_priority_level <= 32'h0000_0000;
    end else begin
      o_priority_level <= {prio_d_r, prio_c_r, prio_b_r, prio_a_r};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      brk_high_r <= ipb_pkg::RST_BYTE;
    end else if (wr_brk_high) begin
      brk_high_r <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      brk_mid_r <= ipb_pkg::RST_BYTE;
    end else if (wr_brk_mid) begin
      brk_mid_r <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      brk_low_r <= ipb_pkg::RST_BYTE;
    end else if (wr_brk_low) begin
      brk_low_r <= i_pwdata[7:0] & ipb_pkg::BRK_LOW_MASK;
    end
  end

  // Only the enable bit of the control word is stored here; the flag has its own process.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      brk_en_r <= 1'b0;
    end else if (wr_brk_ctrl) begin
      brk_en_r <= i_pwdata[ipb_pkg::BRK_EN_BIT];
    end
  end

  // Software is expected to aim the address at an instruction's first byte.
  assign hit = i_fetch.valid && i_fetch.prefetch
    && (i_normal_mode || i_fetch.addr[23:16] == brk_high_r)
    && i_fetch.addr[15:8] == brk_mid_r
    && i_fetch.addr[7:1] == brk_low_r[7:1];

  // A match in the cycle of the acknowledge or a software clear wins over the clear.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      match_flag_r <= 1'b0;
    end else if (brk_en_r && hit) begin
      match_flag_r <= 1'b1;
    end else if (i_break_ack) begin
      match_flag_r <= 1'b0;
    end else if (wr_brk_ctrl && !i_pwdata[ipb_pkg::BRK_FLAG_BIT]) begin
      match_flag_r <= 1'b0;
    end
  end

  // The request is a registered copy so that the CPU sees a clean level.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_break_req <= 1'b0;
    end else begin
      o_break_req <= match_flag_r && brk_en_r;
    end
  end

  // Each sense field is two bits, with the highest request in the top pair.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sense_upper_r <= ipb_pkg::RST_HALF;
    end else if (wr_sense_uh) begin
      sense_upper_r[15:8] <= i_pwdata[7:0];
    end else if (wr_sense_ul) begin
      sense_upper_r[7:0] <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sense_lower_r <= ipb_pkg::RST_HALF;
    end else if (wr_sense_lh) begin
      sense_lower_r[15:8] <= i_pwdata[7:0];
    end else if (wr_sense_ll) begin
      sense_lower_r[7:0] <= i_pwdata[7:0];
    end
  end

  // A set bit routes the alternate pin of that request, 15 to 2 only, into the sense logic.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_sel_r <= ipb_pkg::RST_HALF;
    end else if (wr_pin_sel) begin
      pin_sel_r <= i_pwdata[15:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      req_en_r <= ipb_pkg::RST_HALF;
    end else if (wr_req_en) begin
      req_en_r <= i_pwdata[15:0];
    end
  end

  // Requests 1 and 0 have no alternate pin.
  assign pin_sel_eff = {pin_sel_r[15:2], 2'b00};
  assign raw_in = (i_alt_req_pin_n & pin_sel_eff) | (i_req_pin_n & ~pin_sel_eff);

  // Pins idle high, so the chain starts high and no false edge follows reset.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_r <= 16'hffff;
      sync2_r <= 16'hffff;
      prev_r <= 16'hffff;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < ipb_pkg::NUM_REQ; g++) begin : g_sense
      ipb_pkg::ipb_sense_t mode;
      logic det;
      if (g >= 8) begin : g_up
        assign mode = ipb_pkg::ipb_sense_t'(sense_upper_r[2*(g-8)+1 -: 2]);
      end else begin : g_lo
        assign mode = ipb_pkg::ipb_sense_t'(sense_lower_r[2*g+1 -: 2]);
      end
      always_comb begin
        case (mode)
          ipb_pkg::SENSE_LOW: det = !sync2_r[g];
          ipb_pkg::SENSE_FALL: det = prev_r[g] && !sync2_r[g];
          ipb_pkg::SENSE_RISE: det = !prev_r[g] && sync2_r[g];
          default: det = prev_r[g] ^ sync2_r[g];
        endcase
      end
      assign detect[g] = det;
    end
  endgenerate

  // Edge requests latch until acknowledged; a new edge wins over the acknowledge.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_r <= ipb_pkg::RST_HALF;
    end else begin
      pend_r <= detect | (pend_r & ~i_req_ack);
    end
  end

  // Disabled requests stay pending and appear as soon as they are enabled.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ext_req <= ipb_pkg::RST_HALF;
    end else begin
      o_ext_req <= pend_r & req_en_r;
    end
  end
endmodule : ipb_top

/* File: test/ipb_asserts.sv */
// Checker for the register answers and the break and request outputs of the block.
`timescale 1ns/1ps
module ipb_asserts (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire ipb_pkg::ipb_fetch_t i_fetch,
  input wire logic i_break_ack,
  input wire logic o_break_req,
  input wire logic [15:0] o_ext_req,
  input wire logic [31:0] o_priority_level
);
  logic [11:0] addr_r;
  logic [31:0] wd_r;
  // Keeps the setup address and data so that the answer can be tied to them.
  always_ff @(posedge i_clk) begin
    if (i_psel && !i_penable) begin
      addr_r <= i_paddr;
      wd_r <= i_pwdata;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_pready_answer: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no answer after setup");
  a_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("answer longer than one cycle");
  a_slverr_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without answer");
  a_unmapped_err: assert property (i_psel && !i_penable && i_paddr > ipb_pkg::OFF_REQ_PEND
    |=> o_pslverr) else $error("unmapped access not refused");
  a_prio_stored: assert property (i_psel && !i_penable && i_pwrite &&
    i_paddr == ipb_pkg::OFF_PRIO_A |-> ##2 o_priority_level[7:0] == wd_r[7:0])
    else $error("priority bits do not follow write");
  a_ctrl_reserved: assert property (o_pready && !i_pwrite &&
    addr_r == ipb_pkg::OFF_BRK_CTRL |-> o_prdata[6:1] == 6'h00 && o_prdata[31:8] == 24'h0)
    else $error("control reserved bits not zero");
  a_low_bit_zero: assert property (o_pready && !i_pwrite &&
    addr_r == ipb_pkg::OFF_BRK_LOW |-> o_prdata[0] == 1'h0 && o_prdata[31:8] == 24'h0)
    else $error("low address bit zero not zero");
  a_break_cause: assert property ($rose(o_break_req) |->
    $past(i_fetch.valid && i_fetch.prefetch, 2) ||
    $past(i_psel && i_pwrite && i_paddr == ipb_pkg::OFF_BRK_CTRL, 2))
    else $error("break request without prefetch");
  a_ack_clears: assert property (i_break_ack && !i_fetch.valid |-> ##2 !o_break_req)
    else $error("break request kept after ack");
  a_reset_quiet: assert property ($fell(i_rst) |->
    !o_break_req && o_ext_req == 16'h0000 && o_priority_level == 32'h0)
    else $error("outputs not quiet after reset");
endmodule : ipb_asserts

bind ipb_top ipb_asserts u_asserts (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_fetch(i_fetch),
  .i_break_ack(i_break_ack), .o_break_req(o_break_req), .o_ext_req(o_ext_req),
  .o_priority_level(o_priority_level));

/* File: test/ipb_cpu_model.sv */
// CPU core model that takes break and external requests and acknowledges them.
`timescale 1ns/1ps
module ipb_cpu_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_break_req,
  input wire logic [15:0] i_ext_req,
  output logic o_break_ack,
  output logic [15:0] o_req_ack
);
  logic [2:0] hold_r;
  // After one acknowledge it waits out the request pipeline before looking again.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hold_r <= 3'h0;
      o_break_ack <= 1'h0;
      o_req_ack <= 16'h0000;
    end else begin
      o_break_ack <= i_break_req && hold_r == 3'h0;
      o_req_ack <= (hold_r == 3'h0) ? i_ext_req : 16'h0000;
      if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
      else if (i_break_req || |i_ext_req) hold_r <= 3'h5;
    end
  end
endmodule : ipb_cpu_model

/* File: test/ipb_top_tb_top.sv */
// Testbench for the priority, break and sense block.
`timescale 1ns/1ps
module ipb_top_tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, nmode = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] pin_n = 16'hffff, alt_n = 16'hffff;
  ipb_pkg::ipb_fetch_t fetch = '0;
  logic [31:0] o_prdata, o_priority_level;
  logic o_pready, o_pslverr, o_break_req, brk_ack;
  logic [15:0] o_ext_req, req_ack;
  logic [32:0] expq[$];
  int failures = 0, n_tests = 0, cyc = 0, seed = 42;

  ipb_top uut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_fetch(fetch), .i_normal_mode(nmode),
    .i_break_ack(brk_ack), .i_req_pin_n(pin_n), .i_alt_req_pin_n(alt_n),
    .i_req_ack(req_ack), .o_break_req(o_break_req), .o_ext_req(o_ext_req),
    .o_priority_level(o_priority_level));
  ipb_cpu_model u_cpu (.i_clk(clk), .i_rst(rst), .i_break_req(o_break_req),
    .i_ext_req(o_ext_req), .o_break_ack(brk_ack), .o_req_ack(req_ack));

  initial forever #10 clk = ~clk;

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expq.push_back(e);
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (o_pready !== 1'h1) @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic brk(input logic [23:0] a, input logic pf, input logic nm, input logic ex);
    logic seen;
    seen = 1'h0;
    @(posedge clk);
    fetch <= '{addr: a, valid: 1'h1, prefetch: pf};
    nmode <= nm;
    @(posedge clk);
    fetch.valid <= 1'h0;
    repeat (4) @(posedge clk) seen |= o_break_req;
    check(33'(seen), 33'(ex));
    repeat (8) @(posedge clk);
  endtask : brk

  task automatic pulse(input logic alt, input logic v, output logic s);
    @(posedge clk);
    if (alt) alt_n[15] <= v;
    else pin_n[15] <= v;
    s = 1'h0;
    repeat (10) @(posedge clk) s |= o_ext_req[15];
  endtask : pulse

  // Read answers are compared here in the order in which they were requested.
  always @(posedge clk) begin
    if (psel && penable && !pwrite && o_pready === 1'h1) check({o_pslverr, o_prdata},
      expq.pop_front());
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test;
    end
  end

  initial begin
    logic [31:0] v;
    logic [31:0] pl;
    logic [23:0] ba;
    logic [1:0] m;
    logic sf, sr;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    for (int a = 0; a < 64; a += 4) apb(1'h0, 12'(a), 32'h0, {a == 60, 32'h0});
    $display("reset values done");
    pl = 32'h0;
    for (int k = 0; k < 4; k++) begin
      v = $random(seed) & ((k == 3) ? 32'hc1 : 32'hff);
      pl[8*k +: 8] = v[7:0];
      apb(1'h1, 12'(4 * k), v, 33'h0);
      apb(1'h0, 12'(4 * k), 32'h0, {25'h0, v[7:0]});
    end
    check({1'h0, o_priority_level}, {1'h0, pl});
    $display("priority done");
    apb(1'h1, ipb_pkg::OFF_BRK_CTRL, 32'hff, 33'h0);
    apb(1'h0, ipb_pkg::OFF_BRK_CTRL, 32'h0, 33'h1);
    apb(1'h1, ipb_pkg::OFF_BRK_LOW, 32'hff, 33'h0);
    apb(1'h0, ipb_pkg::OFF_BRK_LOW, 32'h0, 33'hfe);
    ba = 24'($random(seed)) & 24'hfffffe;
    apb(1'h1, ipb_pkg::OFF_BRK_HIGH, {24'h0, ba[23:16]}, 33'h0);
    apb(1'h1, ipb_pkg::OFF_BRK_MID, {24'h0, ba[15:8]}, 33'h0);
    apb(1'h1, ipb_pkg::OFF_BRK_LOW, {24'h0, ba[7:0]}, 33'h0);
    brk(ba, 1'h0, 1'h0, 1'h0);
    brk(ba | 24'h1, 1'h1, 1'h0, 1'h1);
    apb(1'h0, ipb_pkg::OFF_BRK_CTRL, 32'h0, 33'h1);
    brk(ba ^ 24'h010000, 1'h1, 1'h0, 1'h0);
    brk(ba ^ 24'h010000, 1'h1, 1'h1, 1'h1);
    brk(ba ^ 24'h000100, 1'h1, 1'h1, 1'h0);
    apb(1'h1, ipb_pkg::OFF_BRK_CTRL, 32'h0, 33'h0);
    brk(ba, 1'h1, 1'h0, 1'h0);
    $display("address break done");
    for (int i = 0; i < 5; i++) begin
      m = (i == 4) ? 2'h1 : i[1:0];
      apb(1'h1, ipb_pkg::OFF_SENSE_UH, {24'h0, m, 6'h00}, 33'h0);
      apb(1'h1, ipb_pkg::OFF_PIN_SEL, (i == 3) ? 32'h8000 : 32'h0, 33'h0);
      apb(1'h1, ipb_pkg::OFF_REQ_EN, (i == 4) ? 32'h0 : 32'h8000, 33'h0);
      pulse(i == 3, 1'h0, sf);
      pulse(i == 3, 1'h1, sr);
      check(33'(sf), 33'(i != 4 && m != 2'h2));
      if (m != 2'h0) check(33'(sr), 33'(i != 4 && m[1]));
    end
    $display("sense modes done");
    finish_test;
  end
endmodule : ipb_top_tb_top
